// ===== bench/tb_top.sv
// self-checking bench for the extended state enable mask block
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  n_compared++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module tb_top;
  import ese_pkg::*;
  localparam logic [63:0] OSX = 64'h0000_0000_0004_0000;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [1:0] cpl = 2'h0;
  logic [63:0] cr4 = OSX;
  logic [2:0] modes = 3'h0;
  logic [31:0] insn_index = 32'h0;
  logic [63:0] insn_mask = 64'h0;
  logic [6:0] strb = 7'h0;
  logic restore_end = 1'b0;
  logic hi_wr = 1'b0;
  logic hi_from = 1'b0;
  logic [3:0] hi_wr_idx = 4'h0;
  logic [127:0] hi_wdata = 128'h0;
  logic [3:0] hi_rd_idx = 4'h0;
  logic [11:0] area_off = 12'h0;
  logic [127:0] hi_rdata;
  logic insn_done, gp, ud, save_go, restore_go, restore_active, prof_en, area_ign;
  logic [63:0] read_data, sel, mask;
  logic [31:0] q_eax, q_ebx;
  int fail_count = 0;
  int n_compared = 0;

  ese_enable_mask ese_enable_mask_i (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .cpl(cpl),
    .control_reg_four(cr4), .mode_real(modes[0]), .mode_v86(modes[1]),
    .mode_smm(modes[2]), .insn_index(insn_index), .insn_mask(insn_mask),
    .write_ext_ctrl_insn(strb[0]), .read_ext_ctrl_insn(strb[1]),
    .state_save_insn(strb[2]), .optimized_save_insn(strb[3]),
    .state_restore_insn(strb[4]), .feature_query_insn(strb[5]),
    .ext_vec_insn(strb[6]), .restore_end(restore_end), .wide_hi_wr(hi_wr),
    .wide_hi_from_restore(hi_from), .wide_hi_wr_idx(hi_wr_idx),
    .wide_hi_wdata(hi_wdata), .wide_hi_rd_idx(hi_rd_idx),
    .area_byte_offset(area_off), .wide_hi_rdata(hi_rdata), .insn_done(insn_done),
    .general_protection_fault(gp), .invalid_opcode_fault(ud), .read_data(read_data),
    .component_select(sel), .save_go(save_go), .restore_go(restore_go),
    .restore_active(restore_active), .ext_control_reg_zero(mask),
    .profiling_state_enable(prof_en), .query_eax(q_eax), .query_ebx(q_ebx),
    .area_byte_ignored(area_ign)
  );

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic finish_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // k: 0 write, 1 read, 2 save, 3 opt save, 4 restore, 5 query, 6 wide vector
  task automatic do_insn(input int k, input logic [31:0] idx, input logic [63:0] m);
    @(posedge ref_clk);
    insn_index <= idx;
    insn_mask <= m;
    strb <= 7'h01 << k;
    @(posedge ref_clk);
    strb <= 7'h00;
    #1;
    `CHK(insn_done, 1'b1)
  endtask

  task automatic wr_hi(input logic [3:0] idx, input logic [127:0] d, input logic fr);
    @(posedge ref_clk);
    hi_wr <= 1'b1;
    hi_wr_idx <= idx;
    hi_wdata <= d;
    hi_from <= fr;
    @(posedge ref_clk);
    hi_wr <= 1'b0;
    hi_from <= 1'b0;
  endtask

  task automatic rd_hi(input logic [3:0] idx);
    @(posedge ref_clk);
    hi_rd_idx <= idx;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic end_restore();
    @(posedge ref_clk);
    restore_end <= 1'b1;
    @(posedge ref_clk);
    restore_end <= 1'b0;
    #1;
    `CHK(restore_active, 1'b0)
  endtask

  task automatic t_reset();
    `CHK(mask, 64'h1)
    `CHK(prof_en, 1'b0)
    cpl <= 2'h3;
    do_insn(1, 32'h0, 64'h0);
    `CHK(read_data, 64'h1)
    `CHK(gp, 1'b0)
    cpl <= 2'h0;
  endtask

  task automatic t_write();
    logic [63:0] bad [5];
    bad = '{64'h5, 64'h6, 64'h8000_0000_0000_0001, 64'h4000_0000_0000_0001, 64'h9};
    do_insn(0, 32'h0, 64'h7);
    `CHK(gp, 1'b0)
    `CHK(mask, 64'h7)
    // each bad value breaks exactly one of the write checks
    for (int i = 0; i < 5; i++) begin
      do_insn(0, 32'h0, bad[i]);
      `CHK(gp, 1'b1)
      `CHK(mask, 64'h7)
    end
    do_insn(0, 32'h0, 64'h3);
    `CHK(mask, 64'h3)
    do_insn(1, 32'h0, 64'h0);
    `CHK(read_data, 64'h3)
  endtask

  task automatic t_priv();
    cpl <= 2'h3;
    do_insn(0, 32'h0, 64'h7);
    `CHK(gp, 1'b1)
    `CHK(mask, 64'h3)
    do_insn(1, 32'h0, 64'h0);
    `CHK(gp, 1'b0)
    cpl <= 2'h0;
    do_insn(0, 32'h1, 64'h7);
    `CHK(gp, 1'b1)
    do_insn(1, 32'h1, 64'h0);
    `CHK(gp, 1'b1)
  endtask

  task automatic t_osx();
    cr4 <= 64'h0;
    do_insn(0, 32'h0, 64'h7);
    `CHK(ud, 1'b1)
    `CHK(mask, 64'h3)
    do_insn(1, 32'h0, 64'h0);
    `CHK(ud, 1'b1)
    do_insn(6, 32'h0, 64'h0);
    `CHK(ud, 1'b1)
    cr4 <= OSX;
    do_insn(6, 32'h0, 64'h0);
    `CHK(ud, 1'b1)
  endtask

  task automatic t_select();
    do_insn(0, 32'h0, 64'h7);
    do_insn(2, 32'h0, '1);
    `CHK(save_go, 1'b1)
    `CHK(sel, 64'h7)
    do_insn(0, 32'h0, 64'h3);
    do_insn(3, 32'h0, 64'h6);
    `CHK(save_go, 1'b1)
    `CHK(sel, 64'h2)
    do_insn(4, 32'h0, '1);
    `CHK(restore_go, 1'b1)
    `CHK(sel, 64'h3)
    `CHK(restore_active, 1'b0)
    do_insn(0, 32'h0, 64'h7);
    do_insn(4, 32'h0, 64'h5);
    `CHK(sel, 64'h5)
    `CHK(restore_active, 1'b1)
    end_restore();
  endtask

  // clock enable low: a write must leave no trace
  task automatic t_clken();
    @(posedge ref_clk);
    clk_en <= 1'b0;
    insn_index <= 32'h0;
    insn_mask <= 64'h7;
    strb <= 7'h01;
    @(posedge ref_clk);
    strb <= 7'h00;
    clk_en <= 1'b1;
    #1;
    `CHK(insn_done, 1'b0)
    `CHK(mask, 64'h3)
  endtask

  task automatic t_modes();
    do_insn(0, 32'h0, 64'h7);
    for (int i = 0; i < 3; i++) begin
      modes <= 3'h1 << i;
      do_insn(6, 32'h0, 64'h0);
      `CHK(ud, 1'b1)
    end
    modes <= 3'h0;
    do_insn(6, 32'h0, 64'h0);
    `CHK(ud, 1'b0)
    wr_hi(4'h5, {4{32'ha5a5_0f0f}}, 1'b0);
    modes <= 3'h1;
    // outside restore, writes in real mode must be dropped
    wr_hi(4'h5, {4{32'h1234_5678}}, 1'b0);
    rd_hi(4'h5);
    `CHK(hi_rdata, {4{32'ha5a5_0f0f}})
    do_insn(2, 32'h0, '1);
    `CHK(save_go, 1'b1)
    do_insn(4, 32'h0, '1);
    `CHK(restore_go, 1'b1)
    wr_hi(4'h5, {4{32'hc3c3_9696}}, 1'b1);
    end_restore();
    rd_hi(4'h5);
    `CHK(hi_rdata, {4{32'hc3c3_9696}})
    modes <= 3'h0;
  endtask

  task automatic t_query();
    logic [11:0] offs [4];
    logic exp_ign [4];
    offs = '{12'h1cf, 12'h1d0, 12'h1ff, 12'h200};
    exp_ign = '{1'b0, 1'b1, 1'b1, 1'b0};
    do_insn(5, 32'h0, 64'hd);
    `CHK(q_eax, 32'h7)
    `CHK(q_ebx, 32'h340)
    do_insn(0, 32'h0, 64'h3);
    do_insn(5, 32'h0, 64'hd);
    `CHK(q_ebx, 32'h240)
    do_insn(5, 32'h2, 64'hd);
    `CHK(q_eax, 32'h100)
    `CHK(q_ebx, 32'h240)
    do_insn(5, 32'h1, 64'hd);
    `CHK(q_eax, 32'h1)
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      area_off <= offs[i];
      @(posedge ref_clk);
      #1;
      `CHK(area_ign, exp_ign[i])
    end
  endtask

  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_write();
    t_priv();
    t_osx();
    t_select();
    t_modes();
    t_query();
    t_clken();
    finish_test();
  end

  // whole run is about a hundred cycles; this is far beyond it
  initial begin
    #40000;
    fail_count++;
    finish_test();
  end
endmodule

// ===== design/ese_area_layout.sv
// save area layout and feature query answers
`timescale 1ns/10ps
`include "ese_params.svh"
module ese_area_layout
  import ese_pkg::*;
#(
  parameter bit PROF_SUPPORTED = 1'b0
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [63:0] mask,
  input wire logic query_req,
  input wire logic [31:0] leaf,
  input wire logic [31:0] subleaf,
  input wire logic [11:0] area_byte_offset,
  output logic [31:0] query_eax,
  output logic [31:0] query_ebx,
  output logic area_byte_ignored
);
  ese_layout_state_type s_reg;
  ese_layout_state_type s_next;
  logic [63:0] supported;
  logic [31:0] enabled_end;

  always_comb begin
    s_next = s_reg;
    supported = `ESE_SUPPORTED_BASE | (PROF_SUPPORTED ? `ESE_PROF_SUPPORT : 64'h0);
    // size tracks the highest enabled region; offsets never move
    enabled_end = `ESE_HDR_OFF + `ESE_HDR_SIZE;
    if (mask[`ESE_WIDE_BIT]) begin
      enabled_end = `ESE_WIDE_OFF + `ESE_WIDE_SIZE;
    end
    if (mask[`ESE_PROF_BIT]) begin
      enabled_end = `ESE_PROF_OFF + `ESE_PROF_SIZE;
    end
    s_next.ign = (area_byte_offset >= `ESE_IGN_FIRST) &&
                 (area_byte_offset <= `ESE_IGN_LAST);
    if (query_req) begin
      s_next.eax = 32'h0;
      s_next.ebx = 32'h0;
      if (leaf == `ESE_QUERY_LEAF) begin
        if (subleaf == `ESE_SUB_BASE) begin
          s_next.eax = supported[31:0];
          s_next.ebx = enabled_end;
        end else if (subleaf == `ESE_SUB_OPT) begin
          s_next.eax = `ESE_OPT_SAVE_FLAG;
        end else if (subleaf == `ESE_SUB_WIDE) begin
          s_next.eax = `ESE_WIDE_SIZE;
          s_next.ebx = `ESE_WIDE_OFF;
        end else if (subleaf == `ESE_SUB_PROF && PROF_SUPPORTED) begin
          s_next.eax = `ESE_PROF_SIZE;
          s_next.ebx = `ESE_PROF_OFF;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign query_eax = s_reg.eax;
  assign query_ebx = s_reg.ebx;
  assign area_byte_ignored = s_reg.ign;

  ignore_window_a: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && area_byte_offset == `ESE_IGN_FIRST |=> area_byte_ignored)
    else $error("first software byte not ignored");
endmodule

// ===== design/ese_enable_mask.sv
// extended state component enable mask with its instruction checks
`timescale 1ns/10ps
`include "ese_params.svh"
module ese_enable_mask
  import ese_pkg::*;
#(
  parameter bit PROF_SUPPORTED = 1'b0,
  parameter int VEC_REGS = 16,
  parameter int VEC_HI_WIDTH = 128
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [1:0] cpl,
  input wire logic [63:0] control_reg_four,
  input wire logic mode_real,
  input wire logic mode_v86,
  input wire logic mode_smm,
  input wire logic [31:0] insn_index,
  input wire logic [63:0] insn_mask,
  input wire logic write_ext_ctrl_insn,
  input wire logic read_ext_ctrl_insn,
  input wire logic state_save_insn,
  input wire logic optimized_save_insn,
  input wire logic state_restore_insn,
  input wire logic feature_query_insn,
  input wire logic ext_vec_insn,
  input wire logic restore_end,
  input wire logic wide_hi_wr,
  input wire logic wide_hi_from_restore,
  input wire logic [$clog2(VEC_REGS)-1:0] wide_hi_wr_idx,
  input wire logic [VEC_HI_WIDTH-1:0] wide_hi_wdata,
  input wire logic [$clog2(VEC_REGS)-1:0] wide_hi_rd_idx,
  input wire logic [11:0] area_byte_offset,
  output logic [VEC_HI_WIDTH-1:0] wide_hi_rdata,
  output logic insn_done,
  output logic general_protection_fault,
  output logic invalid_opcode_fault,
  output logic [63:0] read_data,
  output logic [63:0] component_select,
  output logic save_go,
  output logic restore_go,
  output logic restore_active,
  output logic [63:0] ext_control_reg_zero,
  output logic profiling_state_enable,
  output logic [31:0] query_eax,
  output logic [31:0] query_ebx,
  output logic area_byte_ignored
);
  localparam int IDX_W = $clog2(VEC_REGS);

  ese_top_state_type s_reg;
  ese_top_state_type s_next;
  logic os_en;
  logic legacy_mode;
  logic [63:0] allowed;
  logic wr_ok;
  logic vec_ok;
  logic hi_wr_en;

  assign os_en = control_reg_four[`ESE_OS_MGMT_BIT];
  assign legacy_mode = mode_real | mode_v86 | mode_smm;
  // bit 62 passes only where profiling exists; otherwise 63:3 must be clear
  assign allowed = `ESE_SUPPORTED_BASE | (PROF_SUPPORTED ? `ESE_PROF_SUPPORT : 64'h0);
  assign wr_ok = ((insn_mask & ~allowed) == 64'h0) &&
                 insn_mask[`ESE_FP_BIT] &&
                 (insn_mask[`ESE_WIDE_BIT:`ESE_V128_BIT] != `ESE_BAD_PAIR);
  assign vec_ok = os_en && !legacy_mode &&
                  (s_reg.mask[`ESE_WIDE_BIT:`ESE_V128_BIT] == `ESE_BOTH_VEC);

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.gp = 1'b0;
    s_next.ud = 1'b0;
    s_next.save_go = 1'b0;
    s_next.restore_go = 1'b0;
    // close first, so a restore taken in the closing cycle reopens the window
    unique case (s_reg.phase)
      ESE_IDLE: begin
      end
      ESE_RESTORE: begin
        if (restore_end) begin
          s_next.phase = ESE_IDLE;
        end
      end
      default: begin
        s_next.phase = ESE_IDLE;
      end
    endcase
    if (write_ext_ctrl_insn) begin
      s_next.done = 1'b1;
      if (!os_en) begin
        s_next.ud = 1'b1;
      end else if (cpl != `ESE_RING0 || insn_index != `ESE_XCR_INDEX0 || !wr_ok) begin
        s_next.gp = 1'b1;
      end else begin
        s_next.mask = insn_mask;
      end
    end else if (read_ext_ctrl_insn) begin
      s_next.done = 1'b1;
      if (!os_en) begin
        s_next.ud = 1'b1;
      end else if (insn_index != `ESE_XCR_INDEX0) begin
        s_next.gp = 1'b1;
      end else begin
        s_next.rdata = s_reg.mask;
      end
    end else if (state_save_insn || optimized_save_insn) begin
      // no mode check: save runs in every mode
      s_next.done = 1'b1;
      if (!os_en) begin
        s_next.ud = 1'b1;
      end else begin
        s_next.sel = insn_mask & s_reg.mask;
        s_next.save_go = 1'b1;
      end
    end else if (state_restore_insn) begin
      s_next.done = 1'b1;
      if (!os_en) begin
        s_next.ud = 1'b1;
      end else begin
        s_next.sel = insn_mask & s_reg.mask;
        s_next.restore_go = 1'b1;
        if (insn_mask[`ESE_WIDE_BIT] && s_reg.mask[`ESE_WIDE_BIT]) begin
          s_next.phase = ESE_RESTORE;
        end
      end
    end else if (feature_query_insn) begin
      s_next.done = 1'b1;
    end else if (ext_vec_insn) begin
      s_next.done = 1'b1;
      s_next.ud = !vec_ok;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.phase <= ESE_IDLE;
      s_reg.mask <= `ESE_MASK_RESET;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // upper halves change only by reset, by restore or by a permitted wide instruction
  assign hi_wr_en = wide_hi_wr && (wide_hi_from_restore ?
                    (s_reg.phase == ESE_RESTORE) : vec_ok);

  ese_upper_mem #(
    .WIDTH(VEC_HI_WIDTH),
    .DEPTH(VEC_REGS),
    .IDX_W(IDX_W)
  ) u_upper_mem (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .wr_en(hi_wr_en),
    .wr_idx(wide_hi_wr_idx),
    .wr_data(wide_hi_wdata),
    .rd_idx(wide_hi_rd_idx),
    .rd_data(wide_hi_rdata)
  );

  ese_area_layout #(
    .PROF_SUPPORTED(PROF_SUPPORTED)
  ) u_area_layout (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .mask(s_reg.mask),
    .query_req(feature_query_insn && !write_ext_ctrl_insn && !read_ext_ctrl_insn),
    .leaf(insn_mask[31:0]),
    .subleaf(insn_index),
    .area_byte_offset(area_byte_offset),
    .query_eax(query_eax),
    .query_ebx(query_ebx),
    .area_byte_ignored(area_byte_ignored)
  );

  assign insn_done = s_reg.done;
  assign general_protection_fault = s_reg.gp;
  assign invalid_opcode_fault = s_reg.ud;
  assign read_data = s_reg.rdata;
  assign component_select = s_reg.sel;
  assign save_go = s_reg.save_go;
  assign restore_go = s_reg.restore_go;
  assign restore_active = (s_reg.phase == ESE_RESTORE);
  assign ext_control_reg_zero = s_reg.mask;
  assign profiling_state_enable = s_reg.mask[`ESE_PROF_BIT];

  sequence write_req_s;
    clk_en && write_ext_ctrl_insn && os_en;
  endsequence

  sequence restore_open_s;
    clk_en && state_restore_insn && !write_ext_ctrl_insn && !read_ext_ctrl_insn &&
    !state_save_insn && !optimized_save_insn && os_en &&
    insn_mask[`ESE_WIDE_BIT] && s_reg.mask[`ESE_WIDE_BIT];
  endsequence

  sequence restore_hold_s;
    restore_active;
  endsequence

  reset_value_a: assert property (@(posedge ref_clk)
    reset |=> ext_control_reg_zero == `ESE_MASK_RESET)
    else $error("mask not at reset value after reset");

  bad_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    write_req_s ##0 !wr_ok |=> general_protection_fault &&
    ext_control_reg_zero == $past(ext_control_reg_zero))
    else $error("illegal write not faulted or mask changed");

  ring_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
    write_req_s ##0 cpl != `ESE_RING0 |=> general_protection_fault &&
    $stable(ext_control_reg_zero))
    else $error("write outside ring 0 accepted");

  mask_legal_a: assert property (@(posedge ref_clk) disable iff (reset)
    ext_control_reg_zero[`ESE_FP_BIT] && !ext_control_reg_zero[`ESE_EXPAND_BIT] &&
    ext_control_reg_zero[`ESE_RSVD_MSB:`ESE_RSVD_LSB] == 59'h0 &&
    ext_control_reg_zero[`ESE_WIDE_BIT:`ESE_V128_BIT] != `ESE_BAD_PAIR)
    else $error("mask holds an illegal value");

  read_back_a: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && read_ext_ctrl_insn && !write_ext_ctrl_insn && os_en &&
    insn_index == `ESE_XCR_INDEX0 |=> insn_done && read_data == ext_control_reg_zero &&
    !general_protection_fault)
    else $error("read does not return the mask");

  os_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && (write_ext_ctrl_insn || read_ext_ctrl_insn) && !os_en |=>
    invalid_opcode_fault && $stable(ext_control_reg_zero))
    else $error("control access without os enable not rejected");

  save_select_a: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && state_save_insn && !write_ext_ctrl_insn && !read_ext_ctrl_insn && os_en
    |=> save_go && component_select == ($past(insn_mask) & $past(ext_control_reg_zero)))
    else $error("save selection is not operand and mask");

  restore_walk_a: assert property (@(posedge ref_clk) disable iff (reset)
    restore_open_s |=> restore_go && component_select[`ESE_WIDE_BIT] ##0 restore_hold_s[*1]
    ##0 restore_active)
    else $error("restore of wide state did not open its window");

  mode_reject_a: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && ext_vec_insn && legacy_mode && !write_ext_ctrl_insn &&
    !read_ext_ctrl_insn && !state_save_insn && !optimized_save_insn &&
    !state_restore_insn && !feature_query_insn |=> invalid_opcode_fault)
    else $error("extended instruction accepted in a legacy mode");

  hi_keep_a: assert property (@(posedge ref_clk) disable iff (reset)
    legacy_mode && !restore_active |-> !hi_wr_en)
    else $error("upper vector state written in a legacy mode");

  good_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    write_req_s ##0 wr_ok && cpl == `ESE_RING0 && insn_index == `ESE_XCR_INDEX0 |=>
    !general_protection_fault && ext_control_reg_zero == $past(insn_mask))
    else $error("valid write not accepted");

  opt_select_a: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && optimized_save_insn && !state_save_insn && !write_ext_ctrl_insn &&
    !read_ext_ctrl_insn && os_en |=> save_go &&
    component_select == ($past(insn_mask) & $past(ext_control_reg_zero)))
    else $error("optimized save selection is not operand and mask");

  restore_select_a: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && state_restore_insn && !write_ext_ctrl_insn && !read_ext_ctrl_insn &&
    !state_save_insn && !optimized_save_insn && os_en |=> restore_go &&
    component_select == ($past(insn_mask) & $past(ext_control_reg_zero)))
    else $error("restore selection is not operand and mask");

  vec_accept_a: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && ext_vec_insn && !write_ext_ctrl_insn && !read_ext_ctrl_insn &&
    !state_save_insn && !optimized_save_insn && !state_restore_insn &&
    !feature_query_insn && vec_ok |=> insn_done && !invalid_opcode_fault)
    else $error("permitted wide instruction rejected");

  restore_close_a: assert property (@(posedge ref_clk) disable iff (reset)
    clk_en && restore_active && restore_end && !state_restore_insn |=> !restore_active)
    else $error("restore window did not close");
endmodule

// ===== design/ese_params.svh
// constants for the extended state enable mask block
`ifndef ESE_PARAMS_SVH
`define ESE_PARAMS_SVH
`define ESE_MASK_RESET 64'h0000_0000_0000_0001
`define ESE_FP_BIT 0
`define ESE_V128_BIT 1
`define ESE_WIDE_BIT 2
`define ESE_RSVD_LSB 3
`define ESE_RSVD_MSB 61
`define ESE_PROF_BIT 62
`define ESE_EXPAND_BIT 63
`define ESE_BAD_PAIR 2'h2
`define ESE_BOTH_VEC 2'h3
`define ESE_OS_MGMT_BIT 18
`define ESE_RING0 2'h0
`define ESE_XCR_INDEX0 32'h0000_0000
`define ESE_QUERY_LEAF 32'h0000_000d
`define ESE_SUPPORTED_BASE 64'h0000_0000_0000_0007
`define ESE_PROF_SUPPORT 64'h4000_0000_0000_0000
`define ESE_LEGACY_OFF 32'h0000_0000
`define ESE_LEGACY_SIZE 32'h0000_0200
`define ESE_HDR_OFF 32'h0000_0200
`define ESE_HDR_SIZE 32'h0000_0040
`define ESE_WIDE_OFF 32'h0000_0240
`define ESE_WIDE_SIZE 32'h0000_0100
`define ESE_PROF_OFF 32'h0000_0340
`define ESE_PROF_SIZE 32'h0000_0080
`define ESE_IGN_FIRST 12'h1d0
`define ESE_IGN_LAST 12'h1ff
`define ESE_SUB_BASE 32'h0000_0000
`define ESE_SUB_OPT 32'h0000_0001
`define ESE_SUB_WIDE 32'h0000_0002
`define ESE_SUB_PROF 32'h0000_003e
`define ESE_OPT_SAVE_FLAG 32'h0000_0001
`endif

// ===== design/ese_pkg.sv
// types shared by the extended state enable mask block
package ese_pkg;
  typedef enum logic [1:0] {
    ESE_IDLE = 2'h1,
    ESE_RESTORE = 2'h2
  } ese_phase_type;

  typedef struct packed {
    ese_phase_type phase;
    logic [63:0] mask;
    logic done;
    logic gp;
    logic ud;
    logic [63:0] rdata;
    logic [63:0] sel;
    logic save_go;
    logic restore_go;
  } ese_top_state_type;

  typedef struct packed {
    logic [31:0] eax;
    logic [31:0] ebx;
    logic ign;
  } ese_layout_state_type;
endpackage

// ===== design/ese_upper_mem.sv
// storage for the upper halves of the wide vector registers
`timescale 1ns/10ps
module ese_upper_mem #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 16,
  parameter int IDX_W = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] word;
    logic [WIDTH-1:0] rd;
  } ese_mem_state_type;

  ese_mem_state_type s_reg;
  ese_mem_state_type s_next;

  // only the write port and reset change contents; mode changes never reach here
  always_comb begin
    s_next = s_reg;
    s_next.rd = s_reg.word[rd_idx];
    if (wr_en) begin
      s_next.word[wr_idx] = wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_reg <= '0;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.rd;
endmodule
